// >>> rtl/pte_channel.sv
// one pulse_train_channel: divider, bit index and loop counter
// assumes start and stop are one-cycle pulses, never both at once.
`default_nettype none

module pte_channel
    import pte_pkg::*;
(
    input  wire logic              sys_clk,   // system clock
    input  wire logic              nrst,      // async reset, low
    input  wire logic              tick,      // module clock enable
    input  wire logic              start,     // restart at bit zero
    input  wire logic              stop,      // disable channel
    input  wire logic              square,    // square wave mode
    input  wire logic [LEN_W-1:0]  len_m1,    // pattern length minus one
    input  wire logic [DIV_W-1:0]  div_exp,   // divide exponent minus one
    input  wire logic [31:0]       pattern,   // pattern bits
    input  wire logic [LOOP_W-1:0] loop_cnt,  // repetition count
    output logic                   out,       // channel output
    output logic                   running,   // enable state
    output logic                   done       // completion pulse
);
    typedef struct packed {
        pte_ch_state_e         st;
        logic [DIVCNT_W-1:0]   div;
        logic [LEN_W-1:0]      idx;
        logic [LOOP_W-1:0]     left;
        logic                  out;
        logic                  done;
    } pte_ch_s;

    pte_ch_s r_reg, r_next;
    logic [DIVCNT_W-1:0] lim;
    logic [LEN_W-1:0]    last;

    function automatic logic bit_at(input logic sq, input logic [31:0] p,
                                    input logic [LEN_W-1:0] i);
        bit_at = sq ? ~i[0] : p[i];
    endfunction : bit_at

    // terminal divider count and last bit index
    always_comb begin
        lim  = (DIVCNT_W'(1) << ({1'b0, div_exp} + 5'h01)) - DIVCNT_W'(1);
        last = (len_m1 < LEN_MIN_M1) ? LEN_MIN_M1 : len_m1;
    end

    // sequencing; start restarts the divider so grouped channels align
    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        if (stop) begin
            r_next.st  = PTE_IDLE;
            r_next.out = IDLE_LVL;
        end else if (start) begin
            r_next.st   = PTE_RUN;
            r_next.div  = '0;
            r_next.idx  = '0;
            r_next.left = loop_cnt;
            r_next.out  = bit_at(square, pattern, '0);
        end else if (r_reg.st == PTE_RUN && tick) begin
            // less-than, not equality: a live change to a shorter divider ends the bit at once, and to a shorter length
            // ends the pass when the bit ends, instead of running the counter round its full range
            if (r_reg.div < lim) begin
                r_next.div = r_reg.div + DIVCNT_W'(1);
            end else begin
                r_next.div = '0;
                if (r_reg.idx < last) begin
                    r_next.idx = r_reg.idx + LEN_W'(1);
                    r_next.out = bit_at(square, pattern, r_reg.idx + LEN_W'(1));
                end else if (r_reg.left == LOOP_W'(1)) begin
                    r_next.st   = PTE_IDLE;
                    r_next.out  = IDLE_LVL;
                    r_next.done = 1'b1;
                end else begin
                    if (r_reg.left != '0) begin
                        r_next.left = r_reg.left - LOOP_W'(1);
                    end
                    r_next.idx = '0;
                    r_next.out = bit_at(square, pattern, '0);
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '{st: PTE_IDLE, div: '0, idx: '0, left: '0,
                       out: IDLE_LVL, done: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign out     = r_reg.out;
    assign running = (r_reg.st == PTE_RUN);
    assign done    = r_reg.done;
endmodule : pte_channel

`default_nettype wire

// >>> rtl/pte_pkg.sv
// constants shared by the pulse train engine top and its channel module
// assumes a single 50 MHz system clock and a plain register port.
// Overview of operation
// - square wave or 2..32 bit pattern
// - chosen channels start locked, bits aligned
// - per-channel enable and settings, isolated
// - set and clear enable words, no rmw
// - start one channel or group together
// - bit rate is clock over power of two
// - module clock from system or independent tick
// - single shot emits pattern once only
// - repeat counted times or endlessly
// - loop end restarts selected other channels
// - channel output overrides pin gpio function
`default_nettype none

package pte_pkg;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    // register byte addresses
    localparam logic [7:0] OFS_ENABLE  = 8'h00; // read: channels running
    localparam logic [7:0] OFS_EN_SET  = 8'h04; // write 1: start channel
    localparam logic [7:0] OFS_EN_CLR  = 8'h08; // write 1: stop channel
    localparam logic [7:0] OFS_DONE    = 8'h0c; // sticky done, write 1 clears
    localparam logic [7:0] OFS_CLKSEL  = 8'h10; // bit 0: independent tick
    localparam logic [7:0] OFS_CH_SEL  = 8'h14; // channel index for window
    localparam logic [7:0] OFS_CH_CFG  = 8'h18; // mode, length, divider
    localparam logic [7:0] OFS_CH_PAT  = 8'h1c; // pattern bits
    localparam logic [7:0] OFS_CH_LOOP = 8'h20; // 0 endless, 1 single shot
    localparam logic [7:0] OFS_CH_RST  = 8'h24; // restart mask on loop end
    localparam logic [7:0] OFS_OUTSTAT = 8'h28; // live channel outputs
    localparam logic [7:0] OFS_ALTFN   = 8'h2c; // pin taken by channel
    // channel config field layout
    localparam int CFG_SQ_BIT  = 0;
    localparam int CFG_LEN_LSB = 1;
    localparam int LEN_W       = 5;
    localparam int CFG_DIV_LSB = 8;
    localparam int DIV_W       = 4;
    localparam int CFG_W       = 12;
    localparam int LOOP_W      = 16;
    localparam int DIVCNT_W    = 17;
    localparam logic [LEN_W-1:0] LEN_MIN_M1 = 5'h01; // two bits least
    localparam logic [CFG_W-1:0] CFG_RST    = 12'h03e; // pattern, 32 bits, /2
    localparam logic [LOOP_W-1:0] LOOP_RST  = 16'h0000;
    localparam logic IDLE_LVL = 1'b0;
    typedef enum logic {PTE_IDLE, PTE_RUN} pte_ch_state_e;
endpackage : pte_pkg

`default_nettype wire

// >>> rtl/pte_top.sv
// pulse train engine: register port, per-channel settings, pin muxing
// assumes synchronous inputs, one clock, and a master that never waits.
`default_nettype none

module pte_top
    import pte_pkg::*;
#(
    parameter int NCH = 16                     // number of channels
)(
    input  wire logic              sys_clk,    // 50 MHz system clock
    input  wire logic              nrst,       // async reset, low
    input  wire logic              ext_tick,   // independent module tick
    input  wire logic [ADDR_W-1:0] addr,       // register byte address
    input  wire logic [DATA_W-1:0] wr_data,    // write data
    input  wire logic              wr_en,      // write strobe
    input  wire logic              rd_en,      // read strobe
    output logic      [DATA_W-1:0] rd_data,    // read data, next cycle
    input  wire logic [NCH-1:0]    gpio_out,   // gpio output levels
    input  wire logic [NCH-1:0]    gpio_oe,    // gpio output enables
    output logic      [NCH-1:0]    pin_out,    // pin output level
    output logic      [NCH-1:0]    pin_oe      // pin driven when high
);
    localparam int SEL_W = $clog2(NCH);

    typedef struct packed {
        logic [NCH-1:0]              start;
        logic [NCH-1:0]              stop;
        logic [NCH-1:0]              done;
        logic                        clksel;
        logic [SEL_W-1:0]            sel;
        logic [NCH-1:0][CFG_W-1:0]   cfg;
        logic [NCH-1:0][31:0]        pat;
        logic [NCH-1:0][LOOP_W-1:0]  loops;
        logic [NCH-1:0][NCH-1:0]     rmask;
        logic [NCH-1:0]              altfn;
        logic [NCH-1:0]              pin;
        logic [NCH-1:0]              oe;
        logic [DATA_W-1:0]           rdata;
    } pte_top_s;

    pte_top_s r_reg, r_next;

    logic           tick;
    logic [NCH-1:0] ch_out;
    logic [NCH-1:0] ch_run;
    logic [NCH-1:0] ch_done;
    logic [NCH-1:0] chain;
    logic [NCH-1:0] wmask;

    assign tick = r_reg.clksel ? ext_tick : 1'b1;

    // one channel per pin, each fed only its own settings
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            pte_channel u_ch (
                .sys_clk  (sys_clk),
                .nrst     (nrst),
                .tick     (tick),
                .start    (r_reg.start[g]),
                .stop     (r_reg.stop[g]),
                .square   (r_reg.cfg[g][CFG_SQ_BIT]),
                .len_m1   (r_reg.cfg[g][CFG_LEN_LSB +: LEN_W]),
                .div_exp  (r_reg.cfg[g][CFG_DIV_LSB +: DIV_W]),
                .pattern  (r_reg.pat[g]),
                .loop_cnt (r_reg.loops[g]),
                .out      (ch_out[g]),
                .running  (ch_run[g]),
                .done     (ch_done[g])
            );
        end
    endgenerate

    // collect restart requests from channels finishing this cycle
    always_comb begin
        chain = '0;
        for (int i = 0; i < NCH; i++) begin
            if (ch_done[i]) begin
                chain = chain | r_reg.rmask[i];
            end
        end
    end

    assign wmask = wr_data[NCH-1:0];

    // register writes, start/stop pulses, done flags, pin mux, reads
    always_comb begin
        r_next       = r_reg;
        r_next.start = chain;
        r_next.stop  = '0;
        // set wins over a clear in the same cycle
        r_next.done  = r_reg.done | ch_done;

        if (wr_en) begin
            if (addr == OFS_EN_SET) begin
                r_next.start = chain | wmask;
            end else if (addr == OFS_EN_CLR) begin
                r_next.stop  = wmask;
                r_next.start = chain & ~wmask;
            end else if (addr == OFS_DONE) begin
                r_next.done = (r_reg.done & ~wmask) | ch_done;
            end else if (addr == OFS_CLKSEL) begin
                r_next.clksel = wr_data[0];
            end else if (addr == OFS_CH_SEL) begin
                r_next.sel = wr_data[SEL_W-1:0];
            end else if (addr == OFS_CH_CFG) begin
                r_next.cfg[r_reg.sel] = wr_data[CFG_W-1:0];
            end else if (addr == OFS_CH_PAT) begin
                r_next.pat[r_reg.sel] = wr_data;
            end else if (addr == OFS_CH_LOOP) begin
                r_next.loops[r_reg.sel] = wr_data[LOOP_W-1:0];
            end else if (addr == OFS_CH_RST) begin
                r_next.rmask[r_reg.sel] = wmask;
            end else if (addr == OFS_ALTFN) begin
                r_next.altfn = wmask;
            end
        end

        for (int i = 0; i < NCH; i++) begin
            r_next.pin[i] = r_reg.altfn[i] ? ch_out[i] : gpio_out[i];
            r_next.oe[i]  = r_reg.altfn[i] ? 1'b1 : gpio_oe[i];
        end

        // read data stands only in the cycle after the strobe
        r_next.rdata = '0;
        if (rd_en) begin
            if (addr == OFS_ENABLE) begin
                r_next.rdata = DATA_W'(ch_run);
            end else if (addr == OFS_DONE) begin
                r_next.rdata = DATA_W'(r_reg.done);
            end else if (addr == OFS_CLKSEL) begin
                r_next.rdata = DATA_W'(r_reg.clksel);
            end else if (addr == OFS_CH_SEL) begin
                r_next.rdata = DATA_W'(r_reg.sel);
            end else if (addr == OFS_CH_CFG) begin
                r_next.rdata = DATA_W'(r_reg.cfg[r_reg.sel]);
            end else if (addr == OFS_CH_PAT) begin
                r_next.rdata = r_reg.pat[r_reg.sel];
            end else if (addr == OFS_CH_LOOP) begin
                r_next.rdata = DATA_W'(r_reg.loops[r_reg.sel]);
            end else if (addr == OFS_CH_RST) begin
                r_next.rdata = DATA_W'(r_reg.rmask[r_reg.sel]);
            end else if (addr == OFS_OUTSTAT) begin
                r_next.rdata = DATA_W'(ch_out);
            end else if (addr == OFS_ALTFN) begin
                r_next.rdata = DATA_W'(r_reg.altfn);
            end
        end
    end

    // reset values; gpio owns every pin until software hands it over
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r_reg        <= '0;
            r_reg.cfg    <= {NCH{CFG_RST}};
            r_reg.loops  <= {NCH{LOOP_RST}};
        end else begin
            r_reg <= r_next;
        end
    end

    assign rd_data = r_reg.rdata;
    assign pin_out = r_reg.pin;
    assign pin_oe  = r_reg.oe;
endmodule : pte_top

`default_nettype wire

// >>> testbench/pte_monitor.sv
// port checker for pte_top, bound to it at the foot
// assumes one clock and the register map of pte_pkg
`default_nettype none

module pte_monitor
    import pte_pkg::*;
#(
    parameter int NCH = 16  // channels
)(
    input wire logic              sys_clk,   // clock
    input wire logic              nrst,      // reset, low
    input wire logic              ext_tick,  // module tick
    input wire logic [ADDR_W-1:0] addr,      // address
    input wire logic [DATA_W-1:0] wr_data,   // write data
    input wire logic              wr_en,     // write strobe
    input wire logic              rd_en,     // read strobe
    input wire logic [DATA_W-1:0] rd_data,   // read data
    input wire logic [NCH-1:0]    gpio_out,  // gpio level
    input wire logic [NCH-1:0]    gpio_oe,   // gpio enable
    input wire logic [NCH-1:0]    pin_out,   // pin level
    input wire logic [NCH-1:0]    pin_oe     // pin enable
);
    typedef struct packed {
        logic [NCH-1:0] alt;
        logic           ext;
    } pte_mon_s;
    pte_mon_s st_reg;
    pte_mon_s st_next;
    // mirror of pin takeover and tick source, written like the device
    always_comb begin
        st_next = st_reg;
        if (wr_en && addr == OFS_ALTFN) st_next.alt = wr_data[NCH-1:0];
        if (wr_en && addr == OFS_CLKSEL) st_next.ext = wr_data[0];
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) st_reg <= '0;
        else st_reg <= st_next;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_rd_idle: assert property (!rd_en |=> rd_data == '0)
        else $error("read data not zero outside a read");
    chk_rd_unmapped: assert property (rd_en && (addr > OFS_ALTFN || addr[1:0] != 2'h0)
        |=> rd_data == '0) else $error("unmapped read not zero");
    chk_wo_read: assert property (rd_en && (addr == OFS_EN_SET || addr == OFS_EN_CLR)
        |=> rd_data == '0) else $error("set or clear word read back");
    chk_gpio_pass: assert property ($past(nrst, 2) |-> (pin_out & ~$past(st_reg.alt))
        == ($past(gpio_out) & ~$past(st_reg.alt))) else $error("gpio level not passed");
    chk_alt_oe: assert property ($past(nrst, 2) |-> pin_oe
        == ($past(st_reg.alt) | $past(gpio_oe))) else $error("pin enable wrong");
    chk_start_en: assert property ((wr_en && addr == OFS_EN_SET) ##1 !wr_en
        ##1 (rd_en && addr == OFS_ENABLE) |=> (rd_data[NCH-1:0] & $past(wr_data[NCH-1:0], 3))
        == $past(wr_data[NCH-1:0], 3)) else $error("started channel not running");
    chk_stop_en: assert property ((wr_en && addr == OFS_EN_CLR) ##1 !wr_en
        ##1 (rd_en && addr == OFS_ENABLE) |=> (rd_data[NCH-1:0] & $past(wr_data[NCH-1:0], 3))
        == '0) else $error("stopped channel still running");
    chk_tick_hold: assert property ((st_reg.ext && !ext_tick && !wr_en) [*4]
        |=> $stable(pin_out & st_reg.alt)) else $error("pin moved without tick");
    cover property (wr_en && addr == OFS_EN_SET && $countones(wr_data[NCH-1:0]) > 1);
    cover property (st_reg.ext && $rose(ext_tick));
    cover property ((rd_en && addr == OFS_DONE) ##1 rd_data != '0);
endmodule : pte_monitor

bind pte_top pte_monitor #(.NCH(NCH)) u_pte_monitor (.sys_clk, .nrst, .ext_tick, .addr,
    .wr_data, .wr_en, .rd_en, .rd_data, .gpio_out, .gpio_oe, .pin_out, .pin_oe);

`default_nettype wire

// >>> testbench/pte_pin_load.sv
// pull-down loads on all 16 pins, whether gpio or a channel drives them
// assumes pin_oe is high while the top drives a pin
`default_nettype none

module pte_pin_load (
    input  wire logic [15:0] pin_out,  // driven level
    input  wire logic [15:0] pin_oe,   // drive enable
    output logic      [15:0] pin_lvl   // wire level
);
    // an undriven pin sinks to the pull-down, never holds its last value
    assign pin_lvl = pin_out & pin_oe;
endmodule : pte_pin_load

`default_nettype wire

// >>> testbench/pulse_train_engine_tb.sv
// self-checking bench for pte_top with pin loads
// assumes the pte_pkg map; the two channel pins of each run are compared every cycle of that run
`default_nettype none

module pulse_train_engine_tb
    import pte_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, nrst = 1'b0, ext_tick = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0]  addr = '0;
    logic [31:0] wr_data = '0, rd_data, rv;
    logic [15:0] gpio_out = '0, gpio_oe = '0, pin_out, pin_oe, pin_lvl;
    int          error_cnt = 0, samples_checked = 0, ch, l, e, n;
    integer      seed = 32'h31f3;

    pte_top #(.NCH(16)) u_pte_top (.sys_clk, .nrst, .ext_tick, .addr, .wr_data, .wr_en,
        .rd_en, .rd_data, .gpio_out, .gpio_oe, .pin_out, .pin_oe);
    pte_pin_load u_pte_pin_load (.pin_out, .pin_oe, .pin_lvl);

    initial forever #10 sys_clk = ~sys_clk;
    // random gpio traffic keeps the pass-through pins busy
    always @(posedge sys_clk) begin
        gpio_out <= 16'($random(seed));
        gpio_oe  <= 16'($random(seed));
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
            error_cnt++;
        end
    endtask : chk
    // expected level k cycles after bit zero shows, idle after the last pass
    function automatic logic exp_bit(int k, logic sq, int l, int e, logic [31:0] p, int n);
        int b;
        b = k >>> (e + 1);
        if (k < 0 || b >= l * n) return 1'b0;
        return sq ? ((b % l) % 2 == 0) : p[b % l];
    endfunction : exp_bit
    // two neighbours, same timing, opposite patterns, started by one write
    task automatic run(int ch, logic sq, int l, int e, logic [31:0] p, int n);
        for (int c = ch; c < ch + 2; c++) begin
            wr(OFS_CH_SEL, 32'(c));
            wr(OFS_CH_CFG, 32'((e << 8) | ((l - 1) << 1) | sq));
            wr(OFS_CH_PAT, c == ch ? p : ~p);
            wr(OFS_CH_LOOP, 32'(n));
            wr(OFS_CH_RST, 32'h0);
        end
        wr(OFS_EN_SET, 32'(3 << ch));
        for (int k = 0; k < ((l * n) << (e + 1)) + 6; k++) begin
            @(posedge sys_clk);
            #1;
            chk(32'(pin_lvl[ch]), 32'(exp_bit(k - 1, sq, l, e, p, n)));
            chk(32'(pin_lvl[ch+1]), 32'(exp_bit(k - 1, sq, l, e, ~p, n)));
        end
        rd(OFS_DONE, rv);
        chk(rv & 32'(3 << ch), 32'(3 << ch));
        wr(OFS_DONE, 32'hffff);
        rd(OFS_ENABLE, rv);
        chk(rv & 32'(3 << ch), 32'h0);
    endtask : run

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        wr(OFS_ALTFN, 32'h00ff);
        rd(8'h40, rv);
        chk(rv, 32'h0);
        run(0, 1'b0, 2, 0, 32'h1, 1);
        run(2, 1'b1, 4, 1, 32'h0, 2);
        run(4, 1'b0, 32, 0, 32'($random(seed)), 1);
        rd(OFS_DONE, rv);
        chk(rv, 32'h0);
        repeat (5) begin
            ch = {$random(seed)} % 6;
            l = 2 + {$random(seed)} % 9;
            e = {$random(seed)} % 3;
            n = 1 + {$random(seed)} % 3;
            run(ch, 1'($random(seed)), l, e, 32'($random(seed)), n);
        end
        // channel 6 single shot hands over to channel 7, which runs endless
        wr(OFS_CH_SEL, 32'h7);
        wr(OFS_CH_LOOP, 32'h0);
        wr(OFS_CH_SEL, 32'h6);
        wr(OFS_CH_CFG, 32'h2);
        rd(OFS_CH_CFG, rv);
        chk(rv, 32'h2);
        wr(OFS_CH_LOOP, 32'h1);
        wr(OFS_CH_RST, 32'h80);
        wr(OFS_EN_SET, 32'h40);
        rd(OFS_ENABLE, rv);
        chk(rv & 32'hc0, 32'h40);
        repeat (200) @(posedge sys_clk);
        rd(OFS_ENABLE, rv);
        chk(rv & 32'hc0, 32'h80);
        wr(OFS_EN_CLR, 32'h80);
        rd(OFS_ENABLE, rv);
        chk(rv & 32'hc0, 32'h0);
        // with the outside tick held low nothing advances
        wr(OFS_CH_RST, 32'h0);
        wr(OFS_CH_PAT, 32'h1);
        wr(OFS_CLKSEL, 32'h1);
        rd(OFS_CLKSEL, rv);
        chk(rv, 32'h1);
        wr(OFS_EN_SET, 32'h40);
        repeat (30) @(posedge sys_clk);
        rd(OFS_ENABLE, rv);
        chk(rv & 32'h40, 32'h40);
        rd(OFS_OUTSTAT, rv);
        chk(rv & 32'h40, 32'h40);
        ext_tick <= 1'b1;
        repeat (30) @(posedge sys_clk);
        rd(OFS_ENABLE, rv);
        chk(rv & 32'h40, 32'h0);
        end_sim();
    end
endmodule : pulse_train_engine_tb

`default_nettype wire
